// ==== design/abc_consts.svh ====
// Constants of the block cipher accelerator: register map, field
// positions, reset values and key-size figures.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses, one aligned word each)
// ---------------------------------------------------------------
`define ABC_ADDR_W 8
`define ABC_OFS_OP 8'h00
`define ABC_OFS_ORDER 8'h04
`define ABC_OFS_START 8'h08
`define ABC_OFS_IDLE 8'h0c
`define ABC_OFS_KEY0 8'h20
`define ABC_MASK_KEY 8'he3
`define ABC_OFS_TEXT0 8'h40
`define ABC_MASK_TEXT 8'hf3

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define ABC_RST_OP 3'h0
`define ABC_RST_ORDER 6'h00
`define ABC_RST_WORD 32'h0000_0000
`define ABC_OP_DEC_BIT 2
`define ABC_OP_SIZE_BAD 2'h3
`define ABC_ORD_KEY_SWAP 0
`define ABC_ORD_KEY_REV 1
`define ABC_ORD_IN_LO 2
`define ABC_ORD_OUT_LO 4
`define ABC_START_BIT 0
`define ABC_IDLE_BIT 0

// ---------------------------------------------------------------
// Key sizes: key words, schedule words, rounds
// ---------------------------------------------------------------
`define ABC_NK_128 4'h4
`define ABC_NK_192 4'h6
`define ABC_NK_256 4'h8
`define ABC_NW_128 6'h2c
`define ABC_NW_192 6'h34
`define ABC_NW_256 6'h3c
`define ABC_NR_128 4'ha
`define ABC_NR_192 4'hc
`define ABC_NR_256 4'he
`define ABC_RCON_INIT 8'h01

`endif

// ==== design/abc_pkg.sv ====
// Shared types and field arithmetic of the block cipher accelerator.
// Assumes nothing of its surroundings.
`default_nettype none

package abc_pkg;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_kexp = 5'b00010,
    st_ark = 5'b00100,
    st_rnd = 5'b01000,
    st_wb = 5'b10000
  } abc_fsm_t;

  // ---------------------------------------------------------------
  // GF(2^8) product, reduction polynomial 0x11b
  // ---------------------------------------------------------------
  function automatic logic [7:0] abc_gf_mul(input logic [7:0] a,
                                            input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
    end
    return p;
  endfunction

endpackage

`default_nettype wire

// ==== design/abc_sbox.sv ====
// Forward or inverse substitution of one byte, computed from the field
// inverse and the affine map rather than from a table.
// Assumes a purely combinational use; the caller registers the result.
`default_nettype none

module abc_sbox (
  input wire logic inv,
  input wire logic [7:0] din,
  output logic [7:0] dout
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rotl(input logic [7:0] b, input int n);
    logic [7:0] r;
    r = b;
    for (int k = 0; k < n; k++) r = {r[6:0], r[7]};
    return r;
  endfunction

  // Inverse as x^254; zero maps to zero as the cipher needs
  function automatic logic [7:0] gf_inv(input logic [7:0] x);
    logic [7:0] r;
    r = 8'h01;
    for (int i = 7; i >= 0; i--) begin
      r = abc_pkg::abc_gf_mul(r, r);
      if (i != 0) r = abc_pkg::abc_gf_mul(r, x);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  wire logic [7:0] pre;
  wire logic [7:0] ginv;
  wire logic [7:0] aff;

  assign pre = inv ? (rotl(din, 1) ^ rotl(din, 3) ^ rotl(din, 6) ^ 8'h05)
                   : din;
  assign ginv = gf_inv(pre);
  assign aff = ginv ^ rotl(ginv, 1) ^ rotl(ginv, 2) ^ rotl(ginv, 3)
             ^ rotl(ginv, 4) ^ 8'h63;
  assign dout = inv ? ginv : aff;

endmodule

`default_nettype wire

// ==== design/abc_mixcol.sv ====
// Forward or inverse column mixing of one 32-bit state column,
// row 0 in the top byte.
// Assumes a purely combinational use; the caller registers the result.
`default_nettype none

module abc_mixcol (
  input wire logic inv,
  input wire logic [31:0] din,
  output logic [31:0] dout
);

  // Circulant coefficient k of the forward or inverse matrix
  function automatic logic [7:0] coef(input logic i, input int k);
    case (k)
      0: coef = i ? 8'h0e : 8'h02;
      1: coef = i ? 8'h0b : 8'h03;
      2: coef = i ? 8'h0d : 8'h01;
      default: coef = i ? 8'h09 : 8'h01;
    endcase
  endfunction

  always_comb begin
    dout = 32'h0;
    for (int r = 0; r < 4; r++) begin
      for (int j = 0; j < 4; j++) begin
        dout[31 - 8 * r -: 8] = dout[31 - 8 * r -: 8]
          ^ abc_pkg::abc_gf_mul(coef(inv, (j - r + 4) % 4),
                                din[31 - 8 * j -: 8]);
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/abc_core.sv ====
// Block cipher accelerator top: register file, key schedule, round
// sequencer and the key and text byte-order mapping.
// Assumes one clock and a register master that never waits.
//
// The implementer's own choices: the register offsets and the strobed register port.
`include "abc_consts.svh"
`default_nettype none


module abc_core (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`ABC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  // ---------------------------------------------------------------
  // Local helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] byte_swap(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // State byte (c, r) sits at byte 4c+r, byte 0 on top
  function automatic logic [127:0] shift_rows(input logic [127:0] s,
                                              input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        src = inv ? (c + 4 - r) % 4 : (c + r) % 4;
        o[127 - 8 * (4 * c + r) -: 8] = s[127 - 8 * (4 * src + r) -: 8];
      end
    end
    return o;
  endfunction

  // Text words (word 0 on top) to state, one select pair
  function automatic logic [127:0] map_in(input logic [127:0] tw,
                                          input logic [1:0] sel);
    logic [127:0] s;
    logic [31:0] w;
    s = '0;
    for (int c = 0; c < 4; c++) begin
      w = sel[1] ? tw[127 - 32 * c -: 32] : tw[127 - 32 * (3 - c) -: 32];
      s[127 - 32 * c -: 32] = sel[0] ? byte_swap(w) : w;
    end
    return s;
  endfunction

  // State back to text words; the inverse of the mapping above
  function automatic logic [127:0] map_out(input logic [127:0] s,
                                           input logic [1:0] sel);
    logic [127:0] tw;
    logic [31:0] w;
    tw = '0;
    for (int c = 0; c < 4; c++) begin
      w = sel[0] ? byte_swap(s[127 - 32 * c -: 32]) : s[127 - 32 * c -: 32];
      if (sel[1]) tw[127 - 32 * c -: 32] = w;
      else tw[127 - 32 * (3 - c) -: 32] = w;
    end
    return tw;
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [2:0] op_r;
  logic [5:0] order_r;
  logic [31:0] key_r [8];
  logic [31:0] text_r [4];
  logic [31:0] ekey_r [60];
  logic [127:0] state_r;
  abc_pkg::abc_fsm_t fsm_r;
  logic [5:0] widx_r;
  logic [3:0] kpos_r;
  logic [7:0] rcon_r;
  logic [3:0] rnd_r;
  logic [31:0] reg_rdata_r;

  // ---------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------
  wire logic dec;
  wire logic [1:0] size;
  wire logic op_ok;
  wire logic [3:0] nk;
  wire logic [5:0] nw;
  wire logic [3:0] nr;
  wire logic idle;

  assign dec = op_r[`ABC_OP_DEC_BIT];
  assign size = op_r[1:0];
  assign op_ok = size != `ABC_OP_SIZE_BAD;
  assign nk = (size == 2'h0) ? `ABC_NK_128 :
              (size == 2'h1) ? `ABC_NK_192 : `ABC_NK_256;
  assign nw = (size == 2'h0) ? `ABC_NW_128 :
              (size == 2'h1) ? `ABC_NW_192 : `ABC_NW_256;
  assign nr = (size == 2'h0) ? `ABC_NR_128 :
              (size == 2'h1) ? `ABC_NR_192 : `ABC_NR_256;
  assign idle = fsm_r == abc_pkg::st_idle;

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  // Configuration writes are dropped while busy so that a half-done
  // operation never sees a mixed key or text.
  wire logic hit_op;
  wire logic hit_order;
  wire logic hit_start;
  wire logic hit_idle;
  wire logic hit_key;
  wire logic hit_text;
  wire logic wr_cfg;
  wire logic start_go;

  assign hit_op = reg_addr == `ABC_OFS_OP;
  assign hit_order = reg_addr == `ABC_OFS_ORDER;
  assign hit_start = reg_addr == `ABC_OFS_START;
  assign hit_idle = reg_addr == `ABC_OFS_IDLE;
  assign hit_key = (reg_addr & `ABC_MASK_KEY) == `ABC_OFS_KEY0;
  assign hit_text = (reg_addr & `ABC_MASK_TEXT) == `ABC_OFS_TEXT0;
  assign wr_cfg = reg_wr && idle;
  assign start_go = wr_cfg && hit_start
                    && reg_wdata[`ABC_START_BIT] && op_ok;

  // ---------------------------------------------------------------
  // Key and text byte-order mapping
  // ---------------------------------------------------------------
  logic [31:0] kmap [8];
  wire logic [127:0] text_cat;
  wire logic [127:0] state_in;
  wire logic [127:0] text_out;

  always_comb begin
    logic [2:0] kidx;
    kidx = 3'h0;
    for (int j = 0; j < 8; j++) begin
      // Words at or above nk are loaded but rewritten by the schedule
      kidx = order_r[`ABC_ORD_KEY_REV] ? 3'(j)
                                       : 3'(nk - 4'(j) - 4'h1);
      kmap[j] = order_r[`ABC_ORD_KEY_SWAP] ? byte_swap(key_r[kidx])
                                           : key_r[kidx];
    end
  end

  assign text_cat = {text_r[0], text_r[1], text_r[2], text_r[3]};
  assign state_in = map_in(text_cat,
                           order_r[`ABC_ORD_IN_LO +: 2]);
  assign text_out = map_out(state_r,
                            order_r[`ABC_ORD_OUT_LO +: 2]);

  // ---------------------------------------------------------------
  // Key schedule, one word per cycle
  // ---------------------------------------------------------------
  wire logic [31:0] prev_w;
  wire logic [31:0] back_w;
  wire logic rot;
  wire logic sub_only;
  wire logic [31:0] ks_in;
  wire logic [31:0] ks_out;
  wire logic [31:0] temp_w;
  wire logic [31:0] new_w;

  assign prev_w = ekey_r[widx_r - 6'h1];
  assign back_w = ekey_r[widx_r - {2'b00, nk}];
  assign rot = kpos_r == 4'h0;
  assign sub_only = (nk == `ABC_NK_256) && (kpos_r == 4'h4);
  assign ks_in = rot ? {prev_w[23:0], prev_w[31:24]} : prev_w;
  assign temp_w = rot ? (ks_out ^ {rcon_r, 24'h0}) :
                  sub_only ? ks_out : prev_w;
  assign new_w = back_w ^ temp_w;

  // ---------------------------------------------------------------
  // Round datapath, shared between both directions
  // ---------------------------------------------------------------
  // One sbox bank and one mix bank serve both directions; the cost
  // is a mux on either side instead of a second full round.
  wire logic [5:0] rk_base;
  wire logic [127:0] rk;
  wire logic [127:0] sb_in;
  wire logic [127:0] sb_out;
  wire logic [127:0] sr_out;
  wire logic [127:0] mix_in;
  wire logic [127:0] mix_out;
  wire logic last;
  wire logic [127:0] round_out;

  assign rk_base = {rnd_r, 2'b00};
  assign rk = {ekey_r[rk_base], ekey_r[rk_base + 6'h1],
               ekey_r[rk_base + 6'h2], ekey_r[rk_base + 6'h3]};
  assign sb_in = dec ? shift_rows(state_r, 1'b1) : state_r;
  assign sr_out = shift_rows(sb_out, 1'b0);
  assign mix_in = dec ? (sb_out ^ rk) : sr_out;
  assign last = dec ? (rnd_r == 4'h0) : (rnd_r == nr);
  assign round_out = dec ? (last ? mix_in : mix_out)
                         : ((last ? sr_out : mix_out) ^ rk);

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_sb
      abc_sbox u_sb (
        .inv(dec),
        .din(sb_in[127 - 8 * g -: 8]),
        .dout(sb_out[127 - 8 * g -: 8])
      );
    end
    for (g = 0; g < 4; g++) begin : g_ks
      abc_sbox u_ks (
        .inv(1'b0),
        .din(ks_in[31 - 8 * g -: 8]),
        .dout(ks_out[31 - 8 * g -: 8])
      );
    end
    for (g = 0; g < 4; g++) begin : g_mc
      abc_mixcol u_mc (
        .inv(dec),
        .din(mix_in[127 - 32 * g -: 32]),
        .dout(mix_out[127 - 32 * g -: 32])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  abc_pkg::abc_fsm_t fsm_nxt;

  always_comb begin
    case (fsm_r)
      abc_pkg::st_idle: fsm_nxt = start_go ? abc_pkg::st_kexp
                                           : abc_pkg::st_idle;
      abc_pkg::st_kexp: fsm_nxt = (widx_r == nw - 6'h1) ? abc_pkg::st_ark
                                                        : abc_pkg::st_kexp;
      abc_pkg::st_ark: fsm_nxt = abc_pkg::st_rnd;
      abc_pkg::st_rnd: fsm_nxt = last ? abc_pkg::st_wb : abc_pkg::st_rnd;
      abc_pkg::st_wb: fsm_nxt = abc_pkg::st_idle;
      default: fsm_nxt = abc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) fsm_r <= abc_pkg::st_idle;
    else fsm_r <= fsm_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      widx_r <= 6'h0;
      kpos_r <= 4'h0;
      rcon_r <= `ABC_RCON_INIT;
    end else if (start_go) begin
      widx_r <= {2'b00, nk};
      kpos_r <= 4'h0;
      rcon_r <= `ABC_RCON_INIT;
    end else if (fsm_r == abc_pkg::st_kexp) begin
      widx_r <= widx_r + 6'h1;
      kpos_r <= (kpos_r == nk - 4'h1) ? 4'h0 : kpos_r + 4'h1;
      if (rot) rcon_r <= abc_pkg::abc_gf_mul(rcon_r, 8'h02);
    end
  end

  // Round index: encrypt walks up from 0, decrypt down from nr
  always_ff @(posedge sys_clk) begin
    if (sys_rst) rnd_r <= 4'h0;
    else if (fsm_r == abc_pkg::st_kexp) rnd_r <= dec ? nr : 4'h0;
    else if (fsm_r == abc_pkg::st_ark || fsm_r == abc_pkg::st_rnd)
      rnd_r <= dec ? rnd_r - 4'h1 : rnd_r + 4'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) state_r <= 128'h0;
    else if (start_go) state_r <= state_in;
    else if (fsm_r == abc_pkg::st_ark) state_r <= state_r ^ rk;
    else if (fsm_r == abc_pkg::st_rnd) state_r <= round_out;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 60; i++) ekey_r[i] <= `ABC_RST_WORD;
    end else if (start_go) begin
      for (int i = 0; i < 8; i++) ekey_r[i] <= kmap[i];
    end else if (fsm_r == abc_pkg::st_kexp) begin
      ekey_r[widx_r] <= new_w;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_r <= `ABC_RST_OP;
      order_r <= `ABC_RST_ORDER;
    end else if (wr_cfg) begin
      if (hit_op) op_r <= reg_wdata[2:0];
      if (hit_order) order_r <= reg_wdata[5:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) key_r[i] <= `ABC_RST_WORD;
    end else if (wr_cfg && hit_key) begin
      key_r[reg_addr[4:2]] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) text_r[i] <= `ABC_RST_WORD;
    end else if (fsm_r == abc_pkg::st_wb) begin
      for (int i = 0; i < 4; i++)
        text_r[i] <= text_out[127 - 32 * i -: 32];
    end else if (wr_cfg && hit_text) begin
      text_r[reg_addr[3:2]] <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Read port: data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  wire logic [31:0] rdata_nxt;

  assign rdata_nxt = !reg_rd ? 32'h0 :
                     hit_op ? {29'h0, op_r} :
                     hit_order ? {26'h0, order_r} :
                     hit_idle ? {31'h0, idle} :
                     hit_key ? key_r[reg_addr[4:2]] :
                     hit_text ? text_r[reg_addr[3:2]] : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) reg_rdata_r <= 32'h0;
    else reg_rdata_r <= rdata_nxt;
  end

  assign reg_rdata = reg_rdata_r;

endmodule

`default_nettype wire

// ==== verif/abc_core_props.sv ====
// Checker of the accelerator register port: read answer timing,
// readback, idle timing and word storage.
// Assumes binding to abc_core; it shadows op, order and busy time.
`include "abc_consts.svh"
`default_nettype none

module abc_core_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [`ABC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  logic [2:0] op_r;
  logic [5:0] ord_r;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  wire logic idle = cnt_r == 7'h00;
  wire logic hit_go = reg_wr && reg_addr == `ABC_OFS_START && reg_wdata[0];
  wire logic go = hit_go && idle && op_r[1:0] != 2'h3;
  wire logic kt = reg_addr[1:0] == 2'h0 &&
                  (reg_addr[7:5] == 3'h1 || reg_addr[7:4] == 4'h4);
  wire logic mapped = kt || (reg_addr[1:0] == 2'h0 && reg_addr < 8'h10);
  // Holds N after the start edge, so it reaches zero on the write-back
  // edge, in step with the sequencer's return to idle
  assign cnt_nxt = !go ? cnt_r - {6'h00, !idle} :
                   op_r[1:0] == 2'h0 ? 7'h34 :
                   op_r[1:0] == 2'h1 ? 7'h3c : 7'h44;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      op_r <= 3'h0;
      ord_r <= 6'h00;
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
      if (reg_wr && idle && reg_addr == `ABC_OFS_OP) op_r <= reg_wdata[2:0];
      if (reg_wr && idle && reg_addr == `ABC_OFS_ORDER) begin
        ord_r <= reg_wdata[5:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_read_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_op_back: assert property (reg_rd && reg_addr == `ABC_OFS_OP
    |=> reg_rdata == {29'h0, op_r}) else $error("op readback wrong");
  a_order_back: assert property (reg_rd && reg_addr == `ABC_OFS_ORDER
    |=> reg_rdata == {26'h0, ord_r}) else $error("order readback wrong");
  a_idle_time: assert property (reg_rd && reg_addr == `ABC_OFS_IDLE
    |=> reg_rdata == {31'h0, $past(idle)}) else $error("idle timing wrong");
  a_unmapped_zero: assert property (reg_rd && (!mapped ||
    reg_addr == `ABC_OFS_START) |=> reg_rdata == 32'h0)
    else $error("unmapped or start read not zero");
  a_word_store: assert property (reg_wr && kt && idle ##1
    reg_rd && $stable(reg_addr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("key or text word not stored");
  a_text_steady: assert property (reg_rd && reg_addr[7:4] == 4'h4 &&
    cnt_r > 7'h01 ##1 reg_rd && $stable(reg_addr) |=> $stable(reg_rdata))
    else $error("text word moved while busy");
  a_bad_op_idle: assert property (hit_go && idle &&
    op_r[1:0] == 2'h3 ##1 reg_rd && reg_addr == `ABC_OFS_IDLE
    |=> reg_rdata[0]) else $error("undefined op left idle");
endmodule

`default_nettype wire

// ==== verif/abc_core_tb.sv ====
// Self-checking bench of the accelerator: reset values, all six ops,
// byte orders, undefined ops, writes while busy, reset mid-run.
// Assumes the checker is compiled first; expects known answer blocks.
`include "abc_consts.svh"
`default_nettype none

module abc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`ABC_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic last_wr = 1'b0;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int e0 = 0;
  logic [127:0] pt = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  logic [127:0] ct [3] = '{128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a,
                           128'hdda9_7ca4_864c_dfe0_6eaf_70a0_ec0d_7191,
                           128'h8ea2_b7ca_5167_45bf_eafc_4990_4b49_6089};

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  abc_core abc_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------
  // Bus tasks and expectations
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Back-to-back writes would assign the strobe twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (last_wr) @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    e0 = cyc;
    last_wr = 1'b1;
  endtask

  task automatic rd2(input logic [7:0] a, output logic [31:0] d0,
                     output logic [31:0] d1);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk) d0 = reg_rdata;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk) d1 = reg_rdata;
    @(posedge sys_clk);
    last_wr = 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] d;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk) d = reg_rdata;
    @(posedge sys_clk);
    last_wr = 1'b0;
    chk(what, exp, d);
  endtask

  function automatic logic [31:0] sw(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Key byte b holds value b; unused words carry junk
  function automatic logic [31:0] kw(input int sz, input int n,
                                     input logic [1:0] o);
    int nk;
    int i;
    nk = 4 + 2 * sz;
    if (n >= nk) return 32'hdead_beef ^ 32'(n);
    i = o[1] ? n : nk - 1 - n;
    return o[0] ? sw({8'(4*i), 8'(4*i+1), 8'(4*i+2), 8'(4*i+3)}) :
                  {8'(4*i), 8'(4*i+1), 8'(4*i+2), 8'(4*i+3)};
  endfunction

  function automatic logic [31:0] tw(input logic [127:0] v, input int m,
                                     input logic [1:0] o);
    logic [31:0] w;
    w = v[127 - 32 * (o[1] ? m : 3 - m) -: 32];
    return o[0] ? sw(w) : w;
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rdchk("op", `ABC_OFS_OP, 32'h0);
    rdchk("order", `ABC_OFS_ORDER, 32'h0);
    rdchk("idle", `ABC_OFS_IDLE, 32'h1);
    rdchk("text", `ABC_OFS_TEXT0 + 8'h0c, 32'h0);
    rdchk("unmapped", 8'h42, 32'h0);
    wr(`ABC_OFS_KEY0 + 8'h1c, 32'ha5a5_5a5a);
    rdchk("key7", `ABC_OFS_KEY0 + 8'h1c, 32'ha5a5_5a5a);
    wr(`ABC_OFS_START, 32'h0);
    rdchk("idle no start", `ABC_OFS_IDLE, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_cipher(input logic [2:0] op, input logic [5:0] o);
    logic [127:0] vin;
    logic [127:0] vout;
    logic [31:0] d0;
    logic [31:0] d1;
    int n;
    int s;
    vin = op[2] ? ct[op[1:0]] : pt;
    vout = op[2] ? pt : ct[op[1:0]];
    n = 52 + 8 * op[1:0];
    wr(`ABC_OFS_OP, {29'h0, op});
    wr(`ABC_OFS_ORDER, {26'h0, o});
    for (int k = 0; k < 8; k++) begin
      wr(`ABC_OFS_KEY0 + 8'(4 * k), kw(op[1:0], k, o[1:0]));
    end
    for (int m = 0; m < 4; m++) begin
      wr(`ABC_OFS_TEXT0 + 8'(4 * m), tw(vin, m, o[3:2]));
    end
    wr(`ABC_OFS_START, 32'h1);
    s = e0;
    // Writes while busy must be dropped
    wr(`ABC_OFS_TEXT0, 32'hffff_ffff);
    wr(`ABC_OFS_OP, 32'h3);
    rd2(`ABC_OFS_TEXT0 + 8'h04, d0, d1);
    chk("text busy", tw(vin, 1, o[3:2]), d1);
    // Write-back lands on edge E0+n; a read taken there still sees busy
    for (int g = 0; g < 100 && cyc != s + n - 1; g++) @(posedge sys_clk);
    if (cyc != s + n - 1) begin
      errors++;
      $display("mismatch wait expected %0d seen %0d", s + n - 1, cyc);
      tally_and_finish();
    end
    rd2(`ABC_OFS_IDLE, d0, d1);
    chk("idle busy", 32'h0, d0);
    chk("idle done", 32'h1, d1);
    for (int m = 0; m < 4; m++) begin
      rdchk("result", `ABC_OFS_TEXT0 + 8'(4 * m), tw(vout, m, o[5:4]));
    end
    rdchk("op kept", `ABC_OFS_OP, {29'h0, op});
    $display("test cipher op %0d order %h done", op, o);
  endtask

  task automatic t_bad(input logic [2:0] op);
    wr(`ABC_OFS_OP, {29'h0, op});
    wr(`ABC_OFS_TEXT0, 32'h1234_5678);
    wr(`ABC_OFS_START, 32'h1);
    rdchk("idle", `ABC_OFS_IDLE, 32'h1);
    rdchk("text", `ABC_OFS_TEXT0, 32'h1234_5678);
    $display("test undefined op %0d done", op);
  endtask

  task automatic t_rerst();
    wr(`ABC_OFS_OP, 32'h2);
    wr(`ABC_OFS_START, 32'h1);
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rdchk("idle", `ABC_OFS_IDLE, 32'h1);
    rdchk("op", `ABC_OFS_OP, 32'h0);
    $display("test reset while busy done");
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    for (int i = 0; i < 7; i++) begin
      if (i != 3) t_cipher(3'(i), 6'h00);
    end
    t_cipher(3'h4, 6'h1e);
    t_cipher(3'h2, 6'h24);
    t_cipher(3'h5, 6'h39);
    t_cipher(3'h6, 6'h3f);
    t_bad(3'h3);
    t_bad(3'h7);
    t_rerst();
    tally_and_finish();
  end
endmodule

bind abc_core abc_core_props abc_core_props_inst (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

`default_nettype wire
